// *** core/tbled_consts.svh ***
// constants of the touch button led output logic
`ifndef TBLED_CONSTS_SVH
`define TBLED_CONSTS_SVH

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define MCLK_HZ         20000000
`define MS_PER_S        1000
`define MS_CYC          (`MCLK_HZ / `MS_PER_S)
`define HOLD_STEP_MS    20
`define AR_SHORT_MS     5000
`define AR_LONG_MS      20000
`define INIT_NORMAL_MS  350
`define INIT_HIGH_MS    1000
`define TIME_UNIT_MS    10
`define PWM_STEPS       100

// ------------------------------------------------------------------
// brightness and threshold
// ------------------------------------------------------------------
`define FULL_BRI        7'h64
`define STBY_0          7'h00
`define STBY_1          7'h14
`define STBY_2          7'h1E
`define STBY_3          7'h32
`define THR_MIN         8'h32
`define THR_MAX         8'hF5

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define A_BTN_EN        5'h00
`define A_SUP_EN        5'h01
`define A_TOG_EN        5'h02
`define A_CFG           5'h03
`define A_HOLD          5'h04
`define A_PO_CFG        5'h05
`define A_STAT_ON       5'h06
`define A_STAT_MISC     5'h07
`define A_PAR_FIRST     5'h08
`define A_PAR_LAST      5'h17

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CF_AUTO_THR     8
`define CF_AR_EN        9
`define CF_AR_LONG      10
`define CF_FX_EN        11
`define CF_BREATHE      12
`define CF_HAND_EN      13
`define CF_STBY_LO      14
`define PC_EN           0
`define PC_SEQ          1
`define PC_NOISE_HIGH   2

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define BTN_EN_RST      10'h3FF
`define CFG_RST         16'h0064
`define PO_CFG_RST      3'h1
`define LED_OFF_RST     10'h3FF

`endif

// *** core/tbled_pkg.sv ***
// types of the touch button led output logic
package tbled_pkg;

	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_RUP  = 5'h02,
		PH_HIGH = 5'h04,
		PH_RDN  = 5'h08,
		PH_LOW  = 5'h10
	} phase_e;

	typedef enum logic [2:0] {
		PO_WAIT = 3'h1,
		PO_RUN  = 3'h2,
		PO_DONE = 3'h4
	} po_e;

	typedef struct packed {
		logic [9:0]        btn_en;
		logic [9:0]        sup_en;
		logic [9:0]        tog_en;
		logic [15:0]       cfg;
		logic [7:0]        hold_cfg;
		logic [2:0]        po_cfg;
		logic [15:0][15:0] par;
		logic [15:0]       rdata;
		logic [14:0]       ms_div;
		logic              ms_tick;
		logic [9:0]        btn_on;
		logic [9:0]        ar_done;
		logic [9:0]        tog;
		logic [3:0]        owner;
		logic              owner_v;
		logic [9:0][14:0]  touch_ms;
		logic              hold_v;
		logic [3:0]        hold_idx;
		logic [12:0]       hold_ms;
		logic [9:0][4:0]   phase;
		logic [9:0][11:0]  tmr;
		logic [9:0][7:0]   rep;
		po_e               po;
		logic [3:0]        po_idx;
		logic              po_started;
		logic [9:0]        po_ms;
		logic [6:0]        pwm;
		logic [9:0]        led_n;
		logic              po_busy;
	} state_s;

endpackage

// *** core/touch_button_led_output_logic.sv ***
// touch button to led output logic with effects, hold, toggle and suppression
//
// Behaviour
// RULE_01: among suppression buttons touched together, only the first one turns on
// RULE_02: each button has its own suppression enable
// RULE_03: an already touched suppression button stays the reported one
// RULE_04: button is on when its signal reaches the finger threshold, manual or automatic
// RULE_05: after release the output stays low for 0 to 5100 ms in 20 ms steps
// RULE_06: hold applies only to the last released output, restarting its counter
// RULE_07: toggle enabled buttons get no release hold
// RULE_08: auto release forces a button off after 5 or 20 s, no hold
// RULE_09: effect parameters shared by outputs 1-3, 4-6, 7-9; output 0 alone
// RULE_10: buttons disabled during power-on effects, run sequentially or concurrently
// RULE_11: power-on effects only on enabled buttons that passed self test
// RULE_12: effects use low/high brightness, four durations and a repeat count
// RULE_13: power-on effects start after 350 or 1000 ms initialization
// RULE_14: writes discarded during power-on effects, reads still answered
// RULE_15: breathing cycles while touched, finishes cycle, then repeats by count
// RULE_16: non-breathing stays high while touched, then high time, down, low, repeat
// RULE_17: a new touch during an active effect restarts it
// RULE_18: toggle with effects alternates between standby and high brightness
// RULE_19: touch effects disable the release hold
// RULE_20: deep sleep stops touch effects at once
// RULE_21: effect handover moves the running effect to the newly touched output
// RULE_22: no handover for toggle buttons or suppressed second buttons
// RULE_23: outputs are active low, strongly driven, following their button
// RULE_24: standby brightness of 0, 20, 30 or 50 percent
// RULE_25: with toggle each new touch inverts the output
// RULE_26: intermediate brightness is made by pulse width modulation
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tbled_consts.svh"

module touch_button_led_output_logic #(
	parameter int unsigned MS_CYC = `MS_CYC
) (
	input  wire logic            mclk_i,
	input  wire logic            rst_i,
	input  wire logic            ce_i,
	input  wire logic [9:0][7:0] touch_input_cnt_i,
	input  wire logic [7:0]      auto_thr_i,
	input  wire logic [9:0]      selftest_fail_i,
	input  wire logic            deep_sleep_i,
	input  wire logic [4:0]      addr_i,
	input  wire logic [15:0]     wdata_i,
	input  wire logic            wr_i,
	input  wire logic            rd_i,
	output logic [15:0]          rdata_o,
	output logic [9:0]           button_led_output_n_o,
	output logic                 po_busy_o
);

	// ------------------------------------------------------------------
	// state and helpers
	// ------------------------------------------------------------------
	localparam logic [14:0] MS_LAST = 15'(MS_CYC - 1);
	localparam tbled_pkg::state_s ST_RST = '{
		btn_en: `BTN_EN_RST, cfg: `CFG_RST, po_cfg: `PO_CFG_RST,
		phase: {10{tbled_pkg::PH_IDLE}}, po: tbled_pkg::PO_WAIT,
		led_n: `LED_OFF_RST, po_busy: 1'b1, default: '0};

	tbled_pkg::state_s st_r;
	tbled_pkg::state_s st_nxt;
	logic [9:0]      raw;
	logic [9:0]      eff;
	logic [9:0]      rise;
	logic [9:0]      fall;
	logic [9:0]      po_start;
	logic [9:0]      active;
	logic [9:0]      sel_mask;
	logic [9:0]      on_nxt;
	logic [3:0]      owner_n;
	logic            owner_vn;
	logic            hand;
	logic            wr_ok;
	logic [6:0]      lvl;
	logic [6:0]      stby;
	logic [7:0]      thr_man;
	logic [7:0]      thr_eff;
	logic [14:0]     ar_lim;
	logic [9:0]      init_lim;
	logic [9:0][6:0] ph_bri;
	logic [9:0][6:0] hi_bri;
	logic [9:0][11:0] dur;
	logic [9:0][7:0] rep_cfg;

	assign thr_man = (st_r.cfg[7:0] < `THR_MIN) ? `THR_MIN :
		(st_r.cfg[7:0] > `THR_MAX) ? `THR_MAX : st_r.cfg[7:0];
	assign thr_eff = st_r.cfg[`CF_AUTO_THR] ? auto_thr_i : thr_man; // RULE_04
	assign ar_lim = st_r.cfg[`CF_AR_LONG] ? 15'(`AR_LONG_MS) : 15'(`AR_SHORT_MS); // RULE_08
	assign init_lim = st_r.po_cfg[`PC_NOISE_HIGH] ? 10'(`INIT_HIGH_MS) : 10'(`INIT_NORMAL_MS); // RULE_13

	always_comb begin
		case (st_r.cfg[`CF_STBY_LO +: 2]) // RULE_24
			2'h0: stby = `STBY_0;
			2'h1: stby = `STBY_1;
			2'h2: stby = `STBY_2;
			default: stby = `STBY_3;
		endcase
	end

	// ------------------------------------------------------------------
	// per output parameters and brightness
	// ------------------------------------------------------------------
	for (genvar g = 0; g < 10; g++) begin : gen_btn
		localparam int GB = (g == 0) ? 0 : ((g - 1) / 3 + 1) * 4; // RULE_09
		logic [6:0]  lo;
		logic [6:0]  hi;
		logic [6:0]  diff;
		logic [7:0]  units;
		logic [6:0]  step;
		assign lo = st_r.par[GB][6:0]; // RULE_12
		assign hi = st_r.par[GB][14:8];
		assign diff = (hi > lo) ? 7'(hi - lo) : 7'h00;
		assign rep_cfg[g] = st_r.par[GB + 3][7:0];
		assign hi_bri[g] = hi;
		assign units = (st_r.phase[g] == tbled_pkg::PH_RUP)  ? st_r.par[GB + 1][15:8] :
			(st_r.phase[g] == tbled_pkg::PH_HIGH) ? st_r.par[GB + 2][7:0] :
			(st_r.phase[g] == tbled_pkg::PH_RDN)  ? st_r.par[GB + 2][15:8] : st_r.par[GB + 1][7:0];
		assign dur[g] = 12'({4'h0, units} * 12'(`TIME_UNIT_MS));
		assign step = (dur[g] == 12'h000) ? diff :
			7'((19'(diff) * 19'(st_r.tmr[g])) / 19'(dur[g])); // RULE_26
		assign ph_bri[g] = (st_r.phase[g] == tbled_pkg::PH_RUP)  ? 7'(lo + step) :
			(st_r.phase[g] == tbled_pkg::PH_HIGH) ? hi :
			(st_r.phase[g] == tbled_pkg::PH_RDN)  ? 7'(hi - step) : lo;
		assign raw[g] = st_r.btn_en[g] && (touch_input_cnt_i[g] >= thr_eff) &&
			(st_r.po == tbled_pkg::PO_DONE) && !deep_sleep_i; // RULE_04
		assign active[g] = (st_r.phase[g] != tbled_pkg::PH_IDLE);
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		lvl = 7'h00;
		st_nxt.ms_tick = 1'b0;
		if (st_r.ms_div == MS_LAST) begin
			st_nxt.ms_div = 15'h0000;
			st_nxt.ms_tick = 1'b1;
		end else begin
			st_nxt.ms_div = 15'(st_r.ms_div + 15'h0001);
		end
		st_nxt.pwm = (st_r.pwm == 7'(`PWM_STEPS - 1)) ? 7'h00 : 7'(st_r.pwm + 7'h01);

		// suppression arbitration
		eff = raw & ~st_r.ar_done; // RULE_08
		sel_mask = 10'h000;
		owner_n = st_r.owner;
		owner_vn = 1'b0;
		if (st_r.owner_v && eff[st_r.owner] && st_r.sup_en[st_r.owner]) begin
			owner_vn = 1'b1; // RULE_03
		end else begin
			for (int i = 9; i >= 0; i--) begin
				if (eff[i] && st_r.sup_en[i]) begin
					owner_n = 4'(i); // RULE_01
					owner_vn = 1'b1;
				end
			end
		end
		if (owner_vn) begin
			sel_mask[owner_n] = 1'b1;
		end
		on_nxt = eff & (~st_r.sup_en | sel_mask); // RULE_02
		rise = on_nxt & ~st_r.btn_on;
		fall = st_r.btn_on & ~on_nxt;
		hand = st_r.cfg[`CF_HAND_EN] && |(rise & ~st_r.tog_en); // RULE_21 RULE_22
		st_nxt.btn_on = on_nxt;
		st_nxt.owner = owner_n;
		st_nxt.owner_v = owner_vn;

		// power-on sequencing
		po_start = 10'h000;
		case (st_r.po)
			tbled_pkg::PO_WAIT: begin
				if (st_r.ms_tick) begin
					if (st_r.po_ms >= 10'(init_lim - 10'h001)) begin // RULE_13
						st_nxt.po = st_r.po_cfg[`PC_EN] ? tbled_pkg::PO_RUN : tbled_pkg::PO_DONE;
					end else begin
						st_nxt.po_ms = 10'(st_r.po_ms + 10'h001);
					end
				end
			end
			tbled_pkg::PO_RUN: begin
				if (!st_r.po_cfg[`PC_SEQ]) begin
					if (!st_r.po_started) begin
						po_start = st_r.btn_en & ~selftest_fail_i; // RULE_10 RULE_11
						st_nxt.po_started = 1'b1;
					end else if (active == 10'h000) begin
						st_nxt.po = tbled_pkg::PO_DONE;
					end
				end else if (!st_r.po_started) begin
					po_start[st_r.po_idx] = st_r.btn_en[st_r.po_idx] && !selftest_fail_i[st_r.po_idx]; // RULE_11
					st_nxt.po_started = 1'b1;
				end else if (!active[st_r.po_idx]) begin
					st_nxt.po_started = 1'b0;
					if (st_r.po_idx == 4'h9) begin
						st_nxt.po = tbled_pkg::PO_DONE;
					end else begin
						st_nxt.po_idx = 4'(st_r.po_idx + 4'h1); // RULE_10
					end
				end
			end
			tbled_pkg::PO_DONE: begin
				st_nxt.po = tbled_pkg::PO_DONE;
			end
			default: begin
				st_nxt.po = tbled_pkg::PO_WAIT;
			end
		endcase
		st_nxt.po_busy = (st_nxt.po != tbled_pkg::PO_DONE);

		// release hold countdown
		if (st_r.hold_v && st_r.ms_tick) begin
			if (st_r.hold_ms == 13'h0000) begin
				st_nxt.hold_v = 1'b0;
			end else begin
				st_nxt.hold_ms = 13'(st_r.hold_ms - 13'h0001); // RULE_05
			end
		end

		for (int i = 0; i < 10; i++) begin
			// auto release
			if (!raw[i] || !st_r.cfg[`CF_AR_EN]) begin
				st_nxt.touch_ms[i] = 15'h0000;
				st_nxt.ar_done[i] = 1'b0;
			end else if (!st_r.ar_done[i] && st_r.ms_tick) begin
				if (st_r.touch_ms[i] >= 15'(ar_lim - 15'h0001)) begin
					st_nxt.ar_done[i] = 1'b1; // RULE_08
				end else begin
					st_nxt.touch_ms[i] = 15'(st_r.touch_ms[i] + 15'h0001);
				end
			end
			if (rise[i] && st_r.tog_en[i]) begin
				st_nxt.tog[i] = ~st_r.tog[i]; // RULE_25
			end
			if (rise[i] && st_nxt.hold_idx == 4'(i)) begin
				st_nxt.hold_v = 1'b0;
			end
			if (fall[i] && !raw[i] && !st_r.tog_en[i] && !st_r.cfg[`CF_FX_EN] &&
				st_r.hold_cfg != 8'h00) begin // RULE_07 RULE_19
				st_nxt.hold_v = 1'b1; // RULE_06
				st_nxt.hold_idx = 4'(i);
				st_nxt.hold_ms = 13'(({5'h00, st_r.hold_cfg} * 13'(`HOLD_STEP_MS)) - 13'h0001); // RULE_05
			end

			// effect engine
			if (active[i]) begin
				if (st_r.phase[i] == tbled_pkg::PH_HIGH && st_r.btn_on[i] && !st_r.cfg[`CF_BREATHE]) begin
					st_nxt.tmr[i] = 12'h000; // RULE_16
				end else if (st_r.tmr[i] >= dur[i]) begin
					st_nxt.tmr[i] = 12'h000;
					case (st_r.phase[i])
						tbled_pkg::PH_RUP:  st_nxt.phase[i] = tbled_pkg::PH_HIGH;
						tbled_pkg::PH_HIGH: st_nxt.phase[i] = tbled_pkg::PH_RDN;
						tbled_pkg::PH_RDN:  st_nxt.phase[i] = tbled_pkg::PH_LOW;
						tbled_pkg::PH_LOW: begin
							if (st_r.cfg[`CF_BREATHE] && st_r.btn_on[i]) begin
								st_nxt.phase[i] = tbled_pkg::PH_RUP; // RULE_15
							end else if (st_r.rep[i] != 8'h00) begin
								st_nxt.rep[i] = 8'(st_r.rep[i] - 8'h01); // RULE_16
								st_nxt.phase[i] = tbled_pkg::PH_RUP;
							end else begin
								st_nxt.phase[i] = tbled_pkg::PH_IDLE;
							end
						end
						default: st_nxt.phase[i] = tbled_pkg::PH_IDLE;
					endcase
				end else if (st_r.ms_tick) begin
					st_nxt.tmr[i] = 12'(st_r.tmr[i] + 12'h001);
				end
			end
			if (po_start[i] || (rise[i] && st_r.cfg[`CF_FX_EN] && !st_r.tog_en[i])) begin
				st_nxt.phase[i] = tbled_pkg::PH_RUP; // RULE_17
				st_nxt.tmr[i] = 12'h000;
				st_nxt.rep[i] = rep_cfg[i];
			end else if (hand && !rise[i] && !st_r.tog_en[i]) begin
				st_nxt.phase[i] = tbled_pkg::PH_IDLE; // RULE_21
			end
			if (deep_sleep_i) begin
				st_nxt.phase[i] = tbled_pkg::PH_IDLE; // RULE_20
			end

			// output level
			if (deep_sleep_i) begin
				lvl = 7'h00;
			end else if (active[i]) begin
				lvl = ph_bri[i];
			end else if (st_r.po != tbled_pkg::PO_DONE) begin
				lvl = 7'h00;
			end else if (st_r.tog_en[i]) begin
				lvl = !st_r.tog[i] ? stby : (st_r.cfg[`CF_FX_EN] ? hi_bri[i] : `FULL_BRI); // RULE_18
			end else if (st_r.cfg[`CF_FX_EN]) begin
				lvl = stby;
			end else begin
				lvl = (st_r.btn_on[i] || (st_r.hold_v && st_r.hold_idx == 4'(i))) ? `FULL_BRI : stby;
			end
			st_nxt.led_n[i] = !(st_r.pwm < lvl); // RULE_23 RULE_26
		end

		// register port
		wr_ok = wr_i && (st_r.po != tbled_pkg::PO_RUN); // RULE_14
		if (wr_ok) begin
			case (addr_i)
				`A_BTN_EN: st_nxt.btn_en = wdata_i[9:0];
				`A_SUP_EN: st_nxt.sup_en = wdata_i[9:0];
				`A_TOG_EN: st_nxt.tog_en = wdata_i[9:0];
				`A_CFG:    st_nxt.cfg = wdata_i;
				`A_HOLD:   st_nxt.hold_cfg = wdata_i[7:0];
				`A_PO_CFG: st_nxt.po_cfg = wdata_i[2:0];
				default: begin
					if (addr_i >= `A_PAR_FIRST && addr_i <= `A_PAR_LAST) begin
						st_nxt.par[4'(addr_i - `A_PAR_FIRST)] = wdata_i;
					end
				end
			endcase
		end
		st_nxt.rdata = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				`A_BTN_EN:    st_nxt.rdata = {6'h00, st_r.btn_en};
				`A_SUP_EN:    st_nxt.rdata = {6'h00, st_r.sup_en};
				`A_TOG_EN:    st_nxt.rdata = {6'h00, st_r.tog_en};
				`A_CFG:       st_nxt.rdata = st_r.cfg;
				`A_HOLD:      st_nxt.rdata = {8'h00, st_r.hold_cfg};
				`A_PO_CFG:    st_nxt.rdata = {13'h0000, st_r.po_cfg};
				`A_STAT_ON:   st_nxt.rdata = {6'h00, st_r.btn_on};
				`A_STAT_MISC: st_nxt.rdata = {9'h000, st_r.po_busy, st_r.hold_v, st_r.owner_v, st_r.owner};
				default: begin
					if (addr_i >= `A_PAR_FIRST && addr_i <= `A_PAR_LAST) begin
						st_nxt.rdata = st_r.par[4'(addr_i - `A_PAR_FIRST)];
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_r <= ST_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign button_led_output_n_o = st_r.led_n;
	assign po_busy_o = st_r.po_busy;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i || !ce_i);

	sup_onehot_a: assert property ($onehot0(st_r.btn_on & st_r.sup_en) || $past(wr_i)) // RULE_01
		else $error("two suppression buttons on");
	sup_free_a: assert property (1'b1 |=> ((st_r.btn_on ^ $past(eff)) & ~$past(st_r.sup_en)) == 10'h000) // RULE_02
		else $error("unsuppressed button not following touch");
	owner_keep_a: assert property (st_r.owner_v && eff[st_r.owner] && st_r.sup_en[st_r.owner] // RULE_03
		|=> st_r.owner_v && st_r.owner == $past(st_r.owner)) else $error("earlier button lost");
	thr_gate_a: assert property (1'b1 |=> (st_r.btn_on & ~$past(raw)) == 10'h000) // RULE_04
		else $error("button on below threshold");
	hold_load_a: assert property (|(fall & ~raw & ~st_r.tog_en) && !st_r.cfg[`CF_FX_EN] && // RULE_06
		st_r.hold_cfg != 8'h00 |=> st_r.hold_v && st_r.hold_ms == 13'(({5'h00, $past(st_r.hold_cfg)} *
		13'(`HOLD_STEP_MS)) - 13'h0001)) else $error("hold not restarted");
	tog_nohold_a: assert property (|(fall & st_r.tog_en) && !(|(fall & ~st_r.tog_en)) && !st_r.hold_v // RULE_07
		|=> !st_r.hold_v) else $error("hold on toggle button");
	fx_nohold_a: assert property (st_r.cfg[`CF_FX_EN] && !st_r.hold_v && !wr_i |=> !st_r.hold_v) // RULE_19
		else $error("hold with effects");
	po_block_a: assert property (st_r.po != tbled_pkg::PO_DONE |=> st_r.btn_on == 10'h000) // RULE_10
		else $error("button on during power-on effects");
	po_elig_a: assert property ((po_start & ~(st_r.btn_en & ~selftest_fail_i)) == 10'h000) // RULE_11
		else $error("power-on effect on disabled or failed output");
	wr_drop_a: assert property (st_r.po == tbled_pkg::PO_RUN && wr_i |=> $stable(st_r.cfg) && // RULE_14
		$stable(st_r.btn_en) && $stable(st_r.par)) else $error("write taken during power-on effects");
	restart_a: assert property (rise[0] && st_r.cfg[`CF_FX_EN] && !st_r.tog_en[0] && !deep_sleep_i // RULE_17
		|=> st_r.phase[0] == tbled_pkg::PH_RUP && st_r.tmr[0] == 12'h000) else $error("effect not restarted");
	sleep_stop_a: assert property (deep_sleep_i |=> active == 10'h000) // RULE_20
		else $error("effect running in deep sleep");

	po_done_c: cover property (st_r.po == tbled_pkg::PO_RUN ##1 st_r.po == tbled_pkg::PO_DONE);
	hold_c: cover property (st_r.hold_v ##1 !st_r.hold_v);
	hand_c: cover property (hand && active != 10'h000);
	ar_c: cover property ($rose(st_r.ar_done[7]));

endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the touch button led output logic
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	localparam int MS = 4;
	logic            mclk_i = 1'b0;
	logic            rst_i = 1'b1;
	logic [9:0]      touched = 10'h000;
	logic [7:0]      strength = 8'hC8;
	logic            sleep = 1'b0;
	logic [4:0]      addr = 5'h00;
	logic [15:0]     wdata = 16'h0000;
	logic            wr = 1'b0;
	logic            rd = 1'b0;
	logic [15:0]     rdata;
	logic [9:0]      led_n;
	logic            busy;
	logic [9:0][7:0] cnt;
	logic [9:0]      lit;
	logic [15:0]     v;
	int              n_errors = 0;
	int              total_checks = 0;

	touch_button_led_output_logic #(.MS_CYC(MS)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
		.touch_input_cnt_i(cnt), .auto_thr_i(8'h80), .selftest_fail_i(10'h200), .deep_sleep_i(sleep),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.button_led_output_n_o(led_n), .po_busy_o(busy));
	touch_led_model partner (.mclk_i(mclk_i), .touched_i(touched), .strength_i(strength),
		.led_n_i(led_n), .touch_input_cnt_o(cnt), .lit_o(lit));

	initial begin
		forever #25 mclk_i = ~mclk_i;
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chk_lit(input logic [9:0] e);
		chk("lit", {6'h00, lit}, {6'h00, e});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic wait_ms(input int n);
		settle(n * MS);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [4:0] a);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic press(input logic [9:0] m, input logic on);
		@(posedge mclk_i);
		touched <= on ? (touched | m) : (touched & ~m);
		settle(8);
	endtask
	task automatic tap(input logic [9:0] m);
		press(m, 1'b1);
		wait_ms(2);
		press(m, 1'b0);
	endtask
	task automatic duty(input int b, input int e);
		int n = 0;
		repeat (100) begin
			@(posedge mclk_i);
			#1 n += int'(lit[b]);
		end
		chk("duty", 16'(n), 16'(e));
	endtask
	task automatic end_sim();
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		#1;
		chk("led_n", {6'h00, led_n}, 16'h03FF);
		chk("busy", {15'h0000, busy}, 16'h0001);
		rd_reg(5'h00);
		chk("btn_en", v, 16'h03FF);
		rd_reg(5'h03);
		chk("cfg", v, 16'h0064);
		rd_reg(5'h05);
		chk("po_cfg", v, 16'h0001);
		rd_reg(5'h1F);
		chk("unmapped", v, 16'h0000);
	endtask
	task automatic t_poweron();
		wr_reg(5'h14, 16'h6464);
		wr_reg(5'h15, 16'h0014);
		wait_ms(450);
		press(10'h002, 1'b1);
		chk_lit(10'h180);
		rd_reg(5'h06);
		chk("btn_on", v, 16'h0000);
		wr_reg(5'h03, 16'h0040);
		rd_reg(5'h03);
		chk("cfg", v, 16'h0064);
		rd_reg(5'h07);
		chk("busy_bit", v & 16'h0040, 16'h0040);
		press(10'h002, 1'b0);
		for (int i = 0; i < 40000 && busy === 1'b1; i++) @(posedge mclk_i);
		wr_reg(5'h03, 16'h0040);
		rd_reg(5'h03);
		chk("cfg", v, 16'h0040);
	endtask
	task automatic t_threshold();
		logic [15:0] cf[6] = '{16'h0040, 16'h0040, 16'h0010, 16'h0010, 16'h0100, 16'h0100};
		logic [7:0]  st[6] = '{8'h40, 8'h3F, 8'h32, 8'h31, 8'h80, 8'h7F};
		for (int i = 0; i < 6; i++) begin
			wr_reg(5'h03, cf[i]);
			strength <= st[i];
			press(10'h004, 1'b1);
			rd_reg(5'h06);
			chk("btn_on", v, (i % 2) ? 16'h0000 : 16'h0004);
			settle(1);
			chk_lit((i % 2) ? 10'h000 : 10'h004);
			press(10'h004, 1'b0);
		end
		strength <= 8'hC8;
		wr_reg(5'h03, 16'h0040);
	endtask
	task automatic t_suppress();
		wr_reg(5'h01, 16'h0006);
		press(10'h004, 1'b1);
		press(10'h00A, 1'b1);
		rd_reg(5'h06);
		chk("btn_on", v, 16'h000C);
		press(10'h00E, 1'b0);
		press(10'h006, 1'b1);
		rd_reg(5'h06);
		chk("btn_on", v, 16'h0002);
		press(10'h006, 1'b0);
	endtask
	task automatic t_hold();
		wr_reg(5'h04, 16'h0005);
		tap(10'h010);
		wait_ms(50);
		chk_lit(10'h010);
		tap(10'h020);
		chk_lit(10'h020);
		wait_ms(80);
		chk_lit(10'h020);
		wait_ms(40);
		chk_lit(10'h000);
	endtask
	task automatic t_toggle();
		wr_reg(5'h02, 16'h0040);
		tap(10'h040);
		wait_ms(150);
		chk_lit(10'h040);
		tap(10'h040);
		wait_ms(5);
		chk_lit(10'h000);
	endtask
	task automatic t_autorel();
		wr_reg(5'h03, 16'h0240);
		press(10'h080, 1'b1);
		wait_ms(4900);
		rd_reg(5'h06);
		chk("btn_on", v, 16'h0080);
		wait_ms(150);
		rd_reg(5'h06);
		chk("btn_on", v, 16'h0000);
		chk_lit(10'h000);
		press(10'h080, 1'b0);
	endtask
	task automatic t_effects();
		wr_reg(5'h03, 16'h4040);
		duty(3, 20);
		wr_reg(5'h0C, 16'h3C0A);
		wr_reg(5'h0E, 16'h0005);
		wr_reg(5'h10, 16'h3200);
		wr_reg(5'h03, 16'h6840);
		tap(10'h040);
		duty(6, 50);
		tap(10'h040);
		duty(6, 20);
		press(10'h002, 1'b1);
		duty(1, 60);
		press(10'h002, 1'b0);
		duty(1, 60);
		wait_ms(60);
		duty(1, 20);
		press(10'h002, 1'b1);
		press(10'h004, 1'b1);
		duty(1, 60);
		duty(2, 20);
		press(10'h008, 1'b1);
		duty(1, 20);
		duty(3, 60);
		press(10'h00E, 1'b0);
		wait_ms(60);
	endtask
	task automatic t_sleep();
		wr_reg(5'h08, 16'h6464);
		wr_reg(5'h03, 16'h0840);
		press(10'h001, 1'b1);
		chk_lit(10'h001);
		@(posedge mclk_i);
		sleep <= 1'b1;
		settle(8);
		chk_lit(10'h000);
		rd_reg(5'h06);
		chk("btn_on", v, 16'h0000);
	endtask

	initial begin
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset();
		t_poweron();
		t_threshold();
		t_suppress();
		t_hold();
		t_toggle();
		t_autorel();
		t_effects();
		t_sleep();
		end_sim();
	end

	initial begin
		repeat (60000) @(posedge mclk_i);
		n_errors++;
		end_sim();
	end
endmodule

`default_nettype wire

// *** verification/touch_led_model.sv ***
// touch pad and led model facing the led output logic
`timescale 1ns/100ps
`default_nettype none

module touch_led_model (
	input  wire logic            mclk_i,
	input  wire logic [9:0]      touched_i,
	input  wire logic [7:0]      strength_i,
	input  wire logic [9:0]      led_n_i,
	output logic [9:0][7:0]      touch_input_cnt_o,
	output logic [9:0]           lit_o
);
	// untouched pads read a count below any threshold
	always_ff @(posedge mclk_i) begin
		for (int i = 0; i < 10; i++) begin
			touch_input_cnt_o[i] <= touched_i[i] ? strength_i : 8'h05;
		end
	end

	// leds sink current into the active low outputs
	assign lit_o = ~led_n_i;
endmodule

`default_nettype wire
